// file: verilog/afd_top.sv
// four-channel output fault diagnostic controller with two-wire slave
//
// Summary of operation
// - diag off: shut only faulty channels
// - restart: sample every 1 ms, resume
// - diag on: overload starts diagnostic automatically
// - recheck after 1 ms; clean means resume
// - overload persists: run 100 ms cycle
// - cycle end: restart mode, store result
// - next cycle only after host read
// - flag output offset beyond two volts
// - offset window: read or enable to read
// - report offset only if whole window
// - protection during test cancels offset report
// - multiple faults: one first, rest later; supply and source-side ground come together
// - priority: supply, then ground, then load
// - permanent diagnostic never reports open load
// - report only faults stable whole period
// - each read re-arms; data from previous
// - eight bits, msb first, then acknowledge
// - receiver pulls data low on acknowledge
// - first byte bit six: diagnostic enable
// - first byte bit five: offset enable
// - second byte bit four: standby off
`timescale 1ns/1ps
`default_nettype none
`include "afd_regs.svh"

module afd_top import afd_pkg::*; #(
	parameter int unsigned CHECK_CYC = `AFD_CHECK_CYC,
	parameter int unsigned DIAG_CYC  = `AFD_DIAG_CYC
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// two-wire bus pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	// output stage comparators, one bit per channel, then the single thermal warning
	input  wire logic [3:0] ch_vs,
	input  wire logic [3:0] ch_gnd_so,
	input  wire logic [3:0] ch_gnd_sk,
	input  wire logic [3:0] ch_sload,
	input  wire logic [3:0] ch_offset_hi,
	input  wire logic       thermal_warn,
	// amplifier control
	output logic [3:0]      ch_enable,
	output logic            diag_enable_bit,
	output logic            offset_enable_bit,
	output logic            standby_control_bit
);

	// pin synchronisers
	logic [1:0] bus_s;
	logic [20:0] pin_s;

	afd_sync #(.W(2)) u_bus_sync (
		.clk (clk),
		.d   ({scl_i, sda_i}),
		.q   (bus_s)
	);

	afd_sync #(.W(21)) u_pin_sync (
		.clk (clk),
		.d   ({thermal_warn, ch_offset_hi, ch_sload, ch_gnd_sk, ch_gnd_so, ch_vs}),
		.q   (pin_s)
	);

	wire scl_s = bus_s[1];
	wire sda_s = bus_s[0];
	wire therm_s = pin_s[20];
	wire [3:0] ofs_hi_s = pin_s[19:16];

	// bus state
	afd_ist_t ist_q;
	logic scl_p_q;
	logic sda_p_q;
	logic [3:0] bcnt_q;
	logic [7:0] sr_q;
	logic [31:0] tx_q;
	logic rw_q;
	logic mack_q;
	logic rd_q;
	logic rd_done_q;
	logic [1:0] bidx_q;
	logic sda_oe_q;
	logic [7:0] ib1_q;
	logic [7:0] ib2_q;
	logic diag_en_q;
	logic ofs_en_q;
	logic ofs_p_q;
	logic stby_q;
	logic [3:0] win_q;
	logic [3:0] ch_en_q;
	logic [31:0] db_w;

	// channel side
	logic [3:0] ch_on_w;
	logic [3:0] prot_w;
	logic [3:0] done_w;
	afd_res_t res_w [4];

	// bus edge and condition decode
	wire scl_rise = scl_s && !scl_p_q;
	wire scl_fall = !scl_s && scl_p_q;
	wire start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
	wire stop_c = scl_s && scl_p_q && !sda_p_q && sda_s;
	wire byte_end = scl_fall && bcnt_q == 4'h8;
	wire addr_hit = sr_q[7:1] == `AFD_DEV_ADDR;
	wire rd_take = ist_q == I_ADDR && byte_end && addr_hit && sr_q[0];
	wire wbyte_take = ist_q == I_WDAT && byte_end;
	wire wr_cfg = wbyte_take && bidx_q == 2'h1;
	wire ofs_rise = ofs_en_q && !ofs_p_q;
	wire win_set = rd_done_q || ofs_rise;

	always_ff @(posedge clk) begin
		scl_p_q <= scl_s;
		sda_p_q <= sda_s;
	end

	// bus slave sequencer; data changes only while the clock is low
	always_ff @(posedge clk) begin
		if (reset || stop_c) begin
			ist_q <= I_IDLE;
			sda_oe_q <= 1'b0;
		end else if (start_c) begin
			ist_q <= I_ADDR;
			bcnt_q <= 4'h0;
			bidx_q <= 2'h0;
			sda_oe_q <= 1'b0;
		end else if (scl_rise) begin
			if (ist_q == I_RACK) begin
				mack_q <= !sda_s;
			end else begin
				sr_q <= {sr_q[6:0], sda_s};
				bcnt_q <= bcnt_q + 4'h1;
			end
		end else if (scl_fall) begin
			case (ist_q)
				I_ADDR: if (byte_end) begin
					ist_q <= addr_hit ? I_AACK : I_IDLE;
					sda_oe_q <= addr_hit;
					rw_q <= sr_q[0];
					tx_q <= db_w;
				end
				I_AACK, I_WACK: begin
					bcnt_q <= 4'h0;
					ist_q <= rw_q ? I_RDAT : I_WDAT;
					sda_oe_q <= rw_q && !tx_q[31];
					tx_q <= {tx_q[30:0], 1'b0};
				end
				I_WDAT: if (byte_end) begin
					ist_q <= I_WACK;
					sda_oe_q <= 1'b1;
					bidx_q <= (bidx_q == 2'h2) ? bidx_q : bidx_q + 2'h1;
				end
				I_RDAT: begin
					if (byte_end) begin
						ist_q <= I_RACK;
						sda_oe_q <= 1'b0;
					end else begin
						sda_oe_q <= !tx_q[31];
						tx_q <= {tx_q[30:0], 1'b0};
					end
				end
				I_RACK: begin
					bcnt_q <= 4'h0;
					ist_q <= mack_q ? I_RDAT : I_IDLE;
					sda_oe_q <= mack_q && !tx_q[31];
					tx_q <= {tx_q[30:0], 1'b0};
				end
				default: ist_q <= I_IDLE;
			endcase
		end
	end

	// a read counts as done when the host ends the transfer
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_q <= 1'b0;
			rd_done_q <= 1'b0;
		end else begin
			rd_done_q <= rd_q && (start_c || stop_c);
			if (start_c || stop_c) begin
				rd_q <= 1'b0;
			end else if (rd_take) begin
				rd_q <= 1'b1;
			end
		end
	end

	// both instruction bytes apply together, so one write can
	// leave standby and enable diagnostics at once
	always_ff @(posedge clk) begin
		if (reset) begin
			ib1_q <= `AFD_IB1_RST;
			ib2_q <= `AFD_IB2_RST;
			diag_en_q <= 1'b0;
			ofs_en_q <= 1'b0;
			stby_q <= 1'b0;
		end else begin
			if (wbyte_take && bidx_q == 2'h0) ib1_q <= sr_q;
			if (wr_cfg) begin
				ib2_q <= sr_q;
				diag_en_q <= ib1_q[`AFD_IB1_DIAG_BIT];
				ofs_en_q <= ib1_q[`AFD_IB1_OFS_BIT];
				stby_q <= sr_q[`AFD_IB2_STBY_BIT];
			end
		end
	end

	// offset window: opens at read end or enable, any gap or
	// protection trip in between clears the channel for good
	always_ff @(posedge clk) begin
		ofs_p_q <= !reset && ofs_en_q;
		if (reset) begin
			win_q <= 4'h0;
		end else if (win_set) begin
			win_q <= 4'hF;
		end else begin
			win_q <= win_q & ofs_hi_s & ~prot_w;
		end
	end

	// four channel sequencers
	for (genvar i = 0; i < 4; i++) begin : g_ch
		afd_chan_diag #(
			.CHECK_CYC (CHECK_CYC),
			.DIAG_CYC  (DIAG_CYC)
		) u_ch (
			.clk     (clk),
			.reset   (reset),
			.diag_en (diag_en_q),
			.rearm   (rd_done_q),
			.flt     (afd_flt_t'({pin_s[i], pin_s[4+i], pin_s[8+i], pin_s[12+i]})),
			.ch_on   (ch_on_w[i]),
			.prot    (prot_w[i]),
			.done    (done_w[i]),
			.res     (res_w[i])
		);
	end

	// read bytes come from the last finished cycle; the offset
	// bit is the window closing at this read
	wire [3:0] ofs_rep = win_q & {4{ofs_en_q}};
	assign db_w = {
		afd_db({therm_s, |done_w}, res_w[0], ofs_rep[0]),
		afd_db({ofs_en_q, 1'b0}, res_w[1], ofs_rep[1]),
		afd_db({stby_q, diag_en_q}, res_w[2], ofs_rep[2]),
		afd_db(2'h0, res_w[3], ofs_rep[3])
	};

	// registered outputs; standby keeps every channel off
	always_ff @(posedge clk) begin
		ch_en_q <= reset ? 4'h0 : ch_on_w & {4{stby_q}};
	end

	assign sda_o = 1'b0;
	assign sda_oe = sda_oe_q;
	assign ch_enable = ch_en_q;
	assign diag_enable_bit = diag_en_q;
	assign offset_enable_bit = ofs_en_q;
	assign standby_control_bit = stby_q;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	byte_ack_a: assert property (wbyte_take && !stop_c && !start_c |=> ist_q == I_WACK && sda_oe_q)
		else $error("written byte not acknowledged");
	read_len_a: assert property ((ist_q == I_RDAT && byte_end && !stop_c && !start_c)
		|=> ist_q == I_RACK && !sda_oe_q) else $error("read byte not eight bits");
	diag_cfg_a: assert property (wr_cfg |=> diag_enable_bit == $past(ib1_q[`AFD_IB1_DIAG_BIT]))
		else $error("diagnostic enable not taken");
	ofs_cfg_a: assert property (wr_cfg |=> offset_enable_bit == $past(ib1_q[`AFD_IB1_OFS_BIT]))
		else $error("offset enable not taken");
	stby_cfg_a: assert property (wr_cfg |=> standby_control_bit == $past(sr_q[4]))
		else $error("standby bit not taken");
	win_open_a: assert property (win_set |=> win_q == 4'hF)
		else $error("offset window not opened");
	win_abort_a: assert property ((!win_set && (prot_w[0] || !ofs_hi_s[0])) |=> !win_q[0])
		else $error("offset kept through gap or trip");
	stby_off_a: assert property (!stby_q |=> ch_en_q == 4'h0)
		else $error("channel on in standby");
	cover_write_c: cover property (wr_cfg);
	cover_read_c: cover property (rd_take ##[1:1000] rd_done_q);
	cover_ofs_c: cover property (rd_take && ofs_rep != 4'h0);

endmodule // afd_top

`default_nettype wire

// file: inc/afd_regs.svh
// bit positions, reset values, bus address and timing counts of the fault diagnostic controller
`ifndef AFD_REGS_SVH
`define AFD_REGS_SVH

// first instruction byte fields
`define AFD_IB1_DIAG_BIT 6
`define AFD_IB1_OFS_BIT 5
// second instruction byte fields
`define AFD_IB2_STBY_BIT 4
// reset values of the instruction bytes
`define AFD_IB1_RST 8'h00
`define AFD_IB2_RST 8'h00

// 7-bit bus address, value arbitrary
`define AFD_DEV_ADDR 7'h3C

// clock rate and diagnostic timing
`define AFD_CLK_KHZ 250000
`define AFD_CHECK_US 1000
`define AFD_CHECK_CYC ((`AFD_CHECK_US * `AFD_CLK_KHZ) / 1000)
`define AFD_DIAG_MS 100
`define AFD_DIAG_CYC (`AFD_DIAG_MS * `AFD_CLK_KHZ)
`define AFD_CNT_W 25

`endif

// file: inc/afd_pkg.sv
// types and byte helpers shared by the fault diagnostic controller
package afd_pkg;

	// comparator view of one channel; open load is not visible here
	typedef struct packed {
		logic supply_short_fault;
		logic ground_short_source_side;
		logic ground_short_sink_side;
		logic shorted_load;
	} afd_flt_t;

	// reported fault of one channel
	typedef struct packed {
		logic sload;
		logic vs;
		logic gnd;
	} afd_res_t;

	typedef enum logic [1:0] {
		C_ACT  = 2'b00,
		C_SHUT = 2'b01,
		C_CHK  = 2'b10,
		C_DIAG = 2'b11
	} afd_cst_t;

	typedef enum logic [2:0] {
		I_IDLE = 3'b000,
		I_ADDR = 3'b001,
		I_AACK = 3'b010,
		I_WDAT = 3'b011,
		I_WACK = 3'b100,
		I_RDAT = 3'b101,
		I_RACK = 3'b110
	} afd_ist_t;

	// one fault out of a pair, supply short first; supply with source-side ground gives both
	function automatic afd_res_t afd_prio(afd_flt_t f);
		afd_res_t r;
		r = '0;
		if (f.supply_short_fault) begin
			r.vs = 1'b1;
			r.gnd = f.ground_short_source_side;
		end else if (f.ground_short_source_side || f.ground_short_sink_side) begin
			r.gnd = 1'b1;
		end else begin
			r.sload = f.shorted_load;
		end
		return r;
	endfunction

	// one diagnostic byte: two status bits, permanent flag, channel result
	function automatic logic [7:0] afd_db(logic [1:0] hi, afd_res_t r, logic ofs);
		return {hi, 1'b0, 1'b1, r.sload, ofs, r.vs, r.gnd};
	endfunction

endpackage

// file: verilog/afd_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module afd_sync #(
	parameter int W = 1
) (
	// clock
	input  wire logic         clk,
	// asynchronous in, synchronous out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// first stage is read by the second only
	always_ff @(posedge clk) begin
		meta_q <= d;
		q <= meta_q;
	end

endmodule // afd_sync

`default_nettype wire

// file: verilog/afd_chan_diag.sv
// per-channel restart and permanent diagnostic sequencer
`timescale 1ns/1ps
`default_nettype none
`include "afd_regs.svh"

module afd_chan_diag import afd_pkg::*; #(
	parameter int unsigned CHECK_CYC = `AFD_CHECK_CYC,
	parameter int unsigned DIAG_CYC  = `AFD_DIAG_CYC
) (
	// clock and reset
	input  wire logic     clk,
	input  wire logic     reset,
	// control
	input  wire logic     diag_en,
	input  wire logic     rearm,
	// synchronised comparators
	input  wire afd_flt_t flt,
	// status
	output logic          ch_on,
	output logic          prot,
	output logic          done,
	output afd_res_t      res
);

	localparam int W = `AFD_CNT_W;

	afd_cst_t st_q;
	afd_cst_t st_d;
	logic [W-1:0] cnt_q;
	logic armed_q;
	afd_flt_t acc_q;

	// protection trips on any short
	assign prot = |flt;
	wire chk_end = cnt_q == W'(CHECK_CYC - 1);
	wire diag_end = cnt_q == W'(DIAG_CYC - 1);
	wire cyc_end = st_q == C_DIAG && diag_end;

	// sequencing; diagnostic only when enabled and re-armed
	always_comb begin
		st_d = st_q;
		case (st_q)
			C_ACT: if (prot) st_d = (diag_en && armed_q) ? C_CHK : C_SHUT;
			C_SHUT: if (chk_end && !prot) st_d = C_ACT;
			C_CHK: if (chk_end) st_d = prot ? C_DIAG : C_ACT;
			C_DIAG: if (diag_end) st_d = C_SHUT;
			default: st_d = C_ACT;
		endcase
	end

	// restart sampling wraps every check period
	always_ff @(posedge clk) begin
		if (reset || st_d != st_q || st_q == C_ACT || (st_q == C_SHUT && chk_end)) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + W'(1);
		end
	end

	always_ff @(posedge clk) begin
		st_q <= reset ? C_ACT : st_d;
		ch_on <= reset || st_d == C_ACT;
	end

	// only a fault held over the whole cycle survives the and
	always_ff @(posedge clk) begin
		if (st_q == C_CHK) begin
			acc_q <= flt;
		end else begin
			acc_q <= afd_flt_t'(acc_q & flt);
		end
	end

	// result store; a finishing cycle wins over a read clearing it
	always_ff @(posedge clk) begin
		if (reset) begin
			done <= 1'b0;
			res <= '0;
		end else if (cyc_end) begin
			done <= 1'b1;
			res <= afd_prio(afd_flt_t'(acc_q & flt));
		end else if (rearm) begin
			done <= 1'b0;
			res <= '0;
		end
	end

	// one cycle per host read
	always_ff @(posedge clk) begin
		if (reset || rearm) begin
			armed_q <= 1'b1;
		end else if (cyc_end) begin
			armed_q <= 1'b0;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	restart_shut_a: assert property ((st_q == C_ACT && prot && !(diag_en && armed_q))
		|=> st_q == C_SHUT && !ch_on) else $error("fault not shut in restart mode");
	restart_hold_a: assert property ((st_q == C_SHUT && !chk_end) |=> st_q != C_ACT)
		else $error("restart before sample point");
	check_clear_a: assert property ((st_q == C_CHK && chk_end && !prot)
		|=> st_q == C_ACT && ch_on) else $error("clean recheck did not resume");
	check_diag_a: assert property ((st_q == C_CHK && chk_end && prot) |=> st_q == C_DIAG)
		else $error("overload recheck did not start cycle");
	cycle_end_a: assert property (cyc_end |=> st_q == C_SHUT && done && !armed_q)
		else $error("cycle end not stored");
	no_rediag_a: assert property ((!armed_q && !rearm) |=> st_q != C_CHK)
		else $error("second cycle without read");
	prio_one_a: assert property ($rose(done) |-> !(res.sload && (res.vs || res.gnd)))
		else $error("two faults reported against priority");
	cover_cycle_c: cover property (st_q == C_CHK ##1 st_q == C_DIAG);

endmodule // afd_chan_diag

`default_nettype wire

// file: verif/afd_host.sv
// two-wire bus host model that configures and reads the fault controller
`timescale 1ns/1ps
`default_nettype none
`include "afd_regs.svh"

module afd_host (
	// clock
	input  wire logic clk,
	// bus wires, data line seen after pull-up
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	// bus idles released, clock stands high outside frames
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// 16 clocks a bit; data moves only while the clock is low
	task automatic bit_io(input logic b, output logic s);
		tick(4);
		sda_low <= ~b;
		tick(4);
		scl <= 1'b1;
		tick(4);
		s = sda;
		tick(4);
		scl <= 1'b0;
	endtask

	task automatic start();
		tick(4);
		sda_low <= 1'b1;
		tick(4);
		scl <= 1'b0;
	endtask

	task automatic stop();
		tick(4);
		sda_low <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_low <= 1'b0;
		tick(8);
	endtask

	// eight bits then the acknowledge slot
	task automatic byte_io(input logic [7:0] d, input logic ak_in, output logic [7:0] q,
		output logic s);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
			q[i] = s;
		end
		bit_io(ak_in, s);
	endtask

	// address, both instruction bytes; stops early when the address is not acknowledged
	task automatic wr(input logic [6:0] a, input logic [7:0] b1, input logic [7:0] b2,
		output logic [2:0] ak);
		logic [7:0] q;
		logic       s;
		start();
		byte_io({a, 1'b0}, 1'b1, q, s);
		ak = {~s, 2'b00};
		if (!s) begin
			byte_io(b1, 1'b1, q, s);
			ak[1] = ~s;
			byte_io(b2, 1'b1, q, s);
			ak[0] = ~s;
		end
		stop();
	endtask

	// four status bytes, host acks all but the last
	task automatic rd(output logic aok, output logic [31:0] db);
		logic [7:0] q;
		logic       s;
		start();
		byte_io({`AFD_DEV_ADDR, 1'b1}, 1'b1, q, s);
		aok = ~s;
		db = '0;
		for (int i = 0; i < 4; i++) begin
			byte_io(8'hFF, i == 3, q, s);
			db = {db[23:0], q};
		end
		stop();
	endtask
endmodule // afd_host
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench of the fault diagnostic controller
`timescale 1ns/1ps
`default_nettype none
`include "afd_regs.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("wrong value %s expected %h seen %h", n, e, g); end end

module testbench import afd_pkg::*;;
	localparam int CK = 20;
	localparam int DG = 100;
	logic        clk, reset;
	logic [3:0]  vs, so, sk, sl, ofs;
	logic [3:0]  ch_en;
	logic        scl, sda_low, sda_o, sda_oe, dg_en, of_en, stby;
	logic        therm;
	wire logic   sda_line;
	int          fails, checks_done;
	logic [31:0] seed, r;
	logic [2:0]  ak;

	// open-drain data line with pull-up
	assign sda_line = ~(sda_low | (sda_oe & ~sda_o));

	afd_host host (.clk(clk), .sda(sda_line), .scl(scl), .sda_low(sda_low));

	afd_top #(.CHECK_CYC(CK), .DIAG_CYC(DG)) DUT (.clk(clk), .reset(reset), .scl_i(scl),
		.sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .ch_vs(vs), .ch_gnd_so(so),
		.ch_gnd_sk(sk), .ch_sload(sl), .ch_offset_hi(ofs), .thermal_warn(therm),
		.ch_enable(ch_en), .diag_enable_bit(dg_en), .offset_enable_bit(of_en),
		.standby_control_bit(stby));

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// reported {sload, vs, gnd} of one channel, supply short first
	function automatic logic [2:0] prio(logic v, logic o, logic k, logic l);
		if (v)
			return {2'b01, o};
		if (o || k)
			return 3'b001;
		return {l, 2'b00};
	endfunction

	function automatic logic [7:0] dbx(logic [1:0] h, logic [2:0] q, logic f);
		return {h, 2'b01, q[2], f, q[1:0]};
	endfunction

	task automatic drive(input logic [19:0] f);
		@(posedge clk);
		{vs, so, sk, sl, ofs} <= f;
	endtask

	task automatic wcfg(input logic [7:0] b1, input logic [7:0] b2);
		host.wr(`AFD_DEV_ADDR, b1, b2, ak);
		`CHK("write ack", 3'b111, ak)
		host.tick(8);
	endtask

	// one read against the expected four bytes
	task automatic rchk(input string n, input logic [5:0] h, input logic [3:0] fo,
		input logic [11:0] q);
		logic        aok;
		logic [31:0] got;
		logic [31:0] x;
		// thermal warning drawn at random, shown as the top bit of the first byte
		x = rnd();
		@(posedge clk);
		therm <= x[0];
		host.tick(4);
		host.rd(aok, got);
		`CHK("read ack", 1'b1, aok)
		`CHK(n, {dbx({x[0], h[4]}, q[2:0], fo[0]), dbx(h[3:2], q[5:3], fo[1]),
			dbx(h[1:0], q[8:6], fo[2]), dbx(2'b00, q[11:9], fo[3])}, got)
		$display("test %s done", n);
	endtask

	task automatic results();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// watchdog, about four and a half times the expected run
	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		results();
	end

	initial begin
		reset = 1'b1;
		{vs, so, sk, sl, ofs} = '0;
		therm = 1'b0;
		seed = 32'd82871;
		fails = 0;
		checks_done = 0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		host.tick(8);
		`CHK("reset state", 7'h00, {ch_en, dg_en, of_en, stby})
		// random instruction bytes land on the applied bits
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			wcfg(r[7:0], r[15:8]);
			`CHK("config", {r[6], r[5], r[12]}, {dg_en, of_en, stby})
		end
		host.wr(`AFD_DEV_ADDR ^ 7'h01, 8'h60, 8'h10, ak);
		`CHK("wrong address ack", 3'b000, ak)
		`CHK("config kept", {r[6], r[5], r[12]}, {dg_en, of_en, stby})
		// restart mode: one random channel and fault kind
		wcfg(8'h00, 8'h10);
		host.tick(CK + 10);
		r = rnd();
		drive(20'h10 << {r[3:2], r[1:0]});
		host.tick(10);
		`CHK("restart shut", ~(4'h1 << r[1:0]), ch_en)
		host.tick(3 * CK);
		`CHK("restart hold", ~(4'h1 << r[1:0]), ch_en)
		drive('0);
		host.tick(CK + 10);
		`CHK("restart resume", 4'hF, ch_en)
		rchk("clean read", 6'b00_00_10, 4'h0, 12'h0);
		// enable diagnostics in one write; standby stays off
		wcfg(8'h40, 8'h10);
		drive(20'h10000);
		host.tick(5);
		drive('0);
		host.tick(CK + 10);
		`CHK("spike skipped", 4'hF, ch_en)
		// fault pairs on channels 0, 1 and 3, a single load short on channel 2; channel 3 drops out briefly mid-cycle
		drive({4'b1001, 4'b0001, 4'b1010, 4'b0110, 4'h0});
		host.tick(CK + 40);
		`CHK("diag shut", 4'h0, ch_en)
		drive({4'b0001, 4'b0001, 4'b0010, 4'b0110, 4'h0});
		host.tick(3);
		drive({4'b1001, 4'b0001, 4'b1010, 4'b0110, 4'h0});
		host.tick(DG + CK);
		drive('0);
		host.tick(CK + 10);
		`CHK("diag resume", 4'hF, ch_en)
		rchk("fault read", 6'b01_00_11, 4'h0, {3'b000, prio(0, 0, 0, 1),
			prio(0, 0, 1, 1), prio(1, 1, 0, 0)});
		// polled again later; the change shows on the second read
		rchk("second read", 6'b00_00_11, 4'h0, 12'h0);
		// offset window from enable to read, random channels high
		r = rnd();
		drive({16'h0000, r[3:0]});
		wcfg(8'h60, 8'h10);
		host.tick(40);
		rchk("offset read", 6'b00_10_11, r[3:0], 12'h0);
		drive(20'h10005);
		host.tick(5);
		drive(20'h5);
		host.tick(CK + 20);
		rchk("offset trip", 6'b00_10_11, 4'h4, 12'h0);
		drive(20'h1);
		host.tick(3);
		drive(20'h5);
		host.tick(20);
		rchk("offset gap", 6'b00_10_11, 4'h1, 12'h0);
		// diagnostics and offset off and standby in one write
		wcfg(8'h00, 8'h00);
		host.tick(8);
		`CHK("standby", 4'h0, ch_en)
		results();
	end
endmodule // testbench
`default_nettype wire
